// File: hw/thsc_top.sv
// Purpose: three fast counters with control, status and staging registers on AXI4-Lite
// Assumes: pins asynchronous to clk; pulses slower than a quarter of clk
// Notes: greater-than compare is signed
//
// Operation
// - status bit reads one while counting up, zero while counting down
// - equality status bit is one whenever count equals preset
// - comparison status bit is one whenever count exceeds preset
// - counter zero reset polarity bit: zero active high, one active low
// - counters one and two reset polarity bit: zero high, one low
// - counters one and two start polarity bit: zero high, one low
// - counter zero quadrature: rate bit zero counts 4x, one counts 1x
// - counters one and two quadrature rate bit: zero 4x, one 1x
// - direction bit one, once applied, counts up; otherwise down
// - direction bit taken over only when direction update bit is one
// - preset update bit one copies staged preset into active preset
// - current update bit one loads staged current value into count
// - counter responds to count inputs only while enable bit is one
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps

module thsc_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [thsc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [thsc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [thsc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [thsc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [thsc_pkg::NUM_CNT-1:0] cntPulse,
  input wire logic [thsc_pkg::NUM_CNT-1:0] cntDir,
  input wire logic [thsc_pkg::NUM_CNT-1:0] cntReset,
  input wire logic [thsc_pkg::NUM_CNT-1:0] cntStart,
  output logic irq
);
  import thsc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] dat,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic isMapped(input logic [IDX_W-1:0] idx);
    logic hit;
    hit = 1'b0;
    for (int c = 0; c < NUM_CNT; c++) begin
      if (idx == IDX_STATUS[c] || idx == IDX_CTRL[c] || idx == IDX_NEWCV[c] ||
          idx == IDX_NEWPV[c]) begin
        hit = 1'b1;
      end
    end
    if (idx >= IDX_LOAD && idx < IDX_PRESET0 + 7'h03) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic awHeld_r;
  logic wHeld_r;
  logic [IDX_W-1:0] awIdx_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic wrEn;
  logic [31:0] rdData;
  logic [31:0] statusAll [NUM_CNT];
  logic [31:0] ctrlAll [NUM_CNT];
  logic [31:0] newCvAll [NUM_CNT];
  logic [31:0] newPvAll [NUM_CNT];
  logic [31:0] countAll [NUM_CNT];
  logic [31:0] presetAll [NUM_CNT];
  logic [2:0] evCh [NUM_CNT];
  logic [EV_W-1:0] irqStat_r;
  logic [EV_W-1:0] irqStat_nxt;
  logic [EV_W-1:0] irqMask_r;
  logic [EV_W-1:0] evSet;
  logic [31:0] config_r;

  assign wrEn = awHeld_r & wHeld_r & ~s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld_r <= 1'b0;
      awIdx_r <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
      awIdx_r <= s_axi_awaddr[ADDR_W-1:2];
      s_axi_awready <= 1'b0;
    end else if (wrEn) begin
      awHeld_r <= 1'b0;
    end else if (!awHeld_r && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wHeld_r <= 1'b0;
      wData_r <= WORD_RST;
      wStrb_r <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wrEn) begin
      wHeld_r <= 1'b0;
    end else if (!wHeld_r && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wrEn) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= isMapped(awIdx_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // status registers read-only: writes to them fall through unstored
  always_comb begin
    logic [IDX_W-1:0] idx;
    idx = s_axi_araddr[ADDR_W-1:2];
    rdData = WORD_RST;
    for (int c = 0; c < NUM_CNT; c++) begin
      if (idx == IDX_STATUS[c]) begin
        rdData = statusAll[c];
      end else if (idx == IDX_CTRL[c]) begin
        rdData = ctrlAll[c];
      end else if (idx == IDX_NEWCV[c]) begin
        rdData = newCvAll[c];
      end else if (idx == IDX_NEWPV[c]) begin
        rdData = newPvAll[c];
      end else if (idx == IDX_COUNT0 + 7'(c)) begin
        rdData = countAll[c];
      end else if (idx == IDX_PRESET0 + 7'(c)) begin
        rdData = presetAll[c];
      end
    end
    if (idx == IDX_IRQ_STAT) begin
      rdData = {23'h00_0000, irqStat_r};
    end else if (idx == IDX_IRQ_MASK) begin
      rdData = {23'h00_0000, irqMask_r};
    end else if (idx == IDX_CONFIG) begin
      rdData = config_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= WORD_RST;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdData;
      s_axi_rresp <= isMapped(s_axi_araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // configuration and interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      config_r <= WORD_RST;
    end else if (wrEn && awIdx_r == IDX_CONFIG) begin
      config_r <= applyStrb(config_r, wData_r, wStrb_r);
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CNT; c++) begin
      evSet[EV_STRIDE*c +: EV_STRIDE] = evCh[c];
    end
  end

  always_comb begin
    logic [31:0] clr;
    clr = WORD_RST;
    if (wrEn && awIdx_r == IDX_IRQ_STAT) begin
      clr = applyStrb(WORD_RST, wData_r, wStrb_r);
    end
    irqStat_nxt = (irqStat_r & ~clr[EV_W-1:0]) | evSet;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irqStat_r <= EV_RST_VAL;
      irqMask_r <= EV_RST_VAL;
      irq <= 1'b0;
    end else begin
      irqStat_r <= irqStat_nxt;
      if (wrEn && awIdx_r == IDX_IRQ_MASK) begin
        irqMask_r <= EV_W'(applyStrb({23'h00_0000, irqMask_r}, wData_r, wStrb_r));
      end
      irq <= |(irqStat_r & irqMask_r);
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4*NUM_CNT-1:0] pinS1_r;
  logic [4*NUM_CNT-1:0] pinS2_r;
  logic [4*NUM_CNT-1:0] pinPrev_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      pinS1_r <= '0;
      pinS2_r <= '0;
      pinPrev_r <= '0;
    end else begin
      pinS1_r <= {cntStart, cntReset, cntDir, cntPulse};
      pinS2_r <= pinS1_r;
      pinPrev_r <= pinS2_r;
    end
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_CNT; i++) begin : gCnt
    logic [7:0] ctrl_r;
    logic [31:0] newCv_r;
    logic [31:0] newPv_r;
    logic [31:0] count_r;
    logic [31:0] preset_r;
    logic dirOp_r;
    logic quadDir_r;
    logic eqPrev_r;
    logic dirPrev_r;
    logic rstPrev_r;
    logic [7:0] cfg;
    thsc_mode_t mode;
    logic a, aP, b, bP, xr, xs;
    logic loadHit, rstAct, startOk, step, up, dirNow, eq, gt;

    assign a = pinS2_r[i];
    assign aP = pinPrev_r[i];
    assign b = pinS2_r[NUM_CNT+i];
    assign bP = pinPrev_r[NUM_CNT+i];
    assign xr = pinS2_r[2*NUM_CNT+i];
    assign xs = pinS2_r[3*NUM_CNT+i];
    assign cfg = config_r[CFG_STRIDE*i +: CFG_STRIDE];
    assign mode = thsc_mode_t'(cfg[1:0]);
    assign loadHit = wrEn && awIdx_r == IDX_LOAD && wStrb_r[0] && wData_r[i];
    assign rstAct = cfg[CFG_RST_EN] && (xr ^ ctrl_r[CTL_RST_POL]);
    assign startOk = (i == 0) || !cfg[CFG_START_EN] || (xs ^ ctrl_r[CTL_START_POL]);
    assign eq = count_r == preset_r;
    assign gt = $signed(count_r) > $signed(preset_r);

    always_comb begin
      case (mode)
        MODE_INT_DIR: begin
          step = a & ~aP;
          up = dirOp_r;
          dirNow = dirOp_r;
        end
        MODE_EXT_DIR: begin
          step = a & ~aP;
          up = b;
          dirNow = b;
        end
        default: begin
          if (!ctrl_r[CTL_RATE]) begin
            step = (a ^ aP) ^ (b ^ bP);
            up = a ^ bP;
          end else begin
            step = a & ~aP;
            up = ~b;
          end
          dirNow = quadDir_r;
        end
      endcase
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        ctrl_r <= CTRL_RST;
      end else if (wrEn && awIdx_r == IDX_CTRL[i] && wStrb_r[0]) begin
        ctrl_r <= wData_r[7:0] & ((i == 0) ? CTRL0_MASK : CTRL_MASK);
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        newCv_r <= WORD_RST;
        newPv_r <= WORD_RST;
      end else if (wrEn && awIdx_r == IDX_NEWCV[i]) begin
        newCv_r <= applyStrb(newCv_r, wData_r, wStrb_r);
      end else if (wrEn && awIdx_r == IDX_NEWPV[i]) begin
        newPv_r <= applyStrb(newPv_r, wData_r, wStrb_r);
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        dirOp_r <= 1'b0;
      end else if (loadHit && ctrl_r[CTL_UPD_DIR]) begin
        dirOp_r <= ctrl_r[CTL_DIR];
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        preset_r <= WORD_RST;
      end else if (loadHit && ctrl_r[CTL_UPD_PV]) begin
        preset_r <= newPv_r;
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        count_r <= WORD_RST;
      end else if (loadHit && ctrl_r[CTL_UPD_CV]) begin
        count_r <= newCv_r;
      end else if (ctrl_r[CTL_EN] && rstAct) begin
        count_r <= WORD_RST;
      end else if (ctrl_r[CTL_EN] && startOk && step) begin
        count_r <= up ? count_r + 32'h0000_0001 : count_r - 32'h0000_0001;
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        quadDir_r <= 1'b0;
      end else if (ctrl_r[CTL_EN] && step) begin
        quadDir_r <= up;
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        eqPrev_r <= 1'b0;
        dirPrev_r <= 1'b0;
        rstPrev_r <= 1'b0;
      end else begin
        eqPrev_r <= eq;
        dirPrev_r <= dirNow;
        rstPrev_r <= rstAct && ctrl_r[CTL_EN];
      end
    end

    assign evCh[i] = {rstAct && ctrl_r[CTL_EN] && !rstPrev_r, dirNow != dirPrev_r,
                      eq && !eqPrev_r};
    assign statusAll[i] = {24'h00_0000, gt, eq, dirNow, 5'h00};
    assign ctrlAll[i] = {24'h00_0000, ctrl_r};
    assign newCvAll[i] = newCv_r;
    assign newPvAll[i] = newPv_r;
    assign countAll[i] = count_r;
    assign presetAll[i] = preset_r;
  end

endmodule // thsc_top

// File: hw/thsc_pkg.sv
// Purpose: shared constants for the triple high-speed counter block
// Assumes: register indices are word indices; byte address is four times the index
// Notes: 32-bit AXI4-Lite data, each register in one aligned word

package thsc_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int NUM_CNT = 3;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int IDX_W = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_C0_STATUS = 7'h24;
  localparam logic [IDX_W-1:0] IDX_C0_CTRL = 7'h25;
  localparam logic [IDX_W-1:0] IDX_C0_NEWCV = 7'h26;
  localparam logic [IDX_W-1:0] IDX_C0_NEWPV = 7'h2a;
  localparam logic [IDX_W-1:0] IDX_C1_STATUS = 7'h2e;
  localparam logic [IDX_W-1:0] IDX_C1_CTRL = 7'h2f;
  localparam logic [IDX_W-1:0] IDX_C1_NEWCV = 7'h30;
  localparam logic [IDX_W-1:0] IDX_C1_NEWPV = 7'h34;
  localparam logic [IDX_W-1:0] IDX_C2_STATUS = 7'h38;
  localparam logic [IDX_W-1:0] IDX_C2_CTRL = 7'h39;
  localparam logic [IDX_W-1:0] IDX_C2_NEWCV = 7'h3a;
  localparam logic [IDX_W-1:0] IDX_C2_NEWPV = 7'h3e;
  localparam logic [IDX_W-1:0] IDX_LOAD = 7'h40;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 7'h41;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 7'h42;
  localparam logic [IDX_W-1:0] IDX_CONFIG = 7'h43;
  localparam logic [IDX_W-1:0] IDX_COUNT0 = 7'h44;
  localparam logic [IDX_W-1:0] IDX_PRESET0 = 7'h47;

  localparam logic [IDX_W-1:0] IDX_STATUS [NUM_CNT] = '{IDX_C0_STATUS, IDX_C1_STATUS,
    IDX_C2_STATUS};
  localparam logic [IDX_W-1:0] IDX_CTRL [NUM_CNT] = '{IDX_C0_CTRL, IDX_C1_CTRL, IDX_C2_CTRL};
  localparam logic [IDX_W-1:0] IDX_NEWCV [NUM_CNT] = '{IDX_C0_NEWCV, IDX_C1_NEWCV,
    IDX_C2_NEWCV};
  localparam logic [IDX_W-1:0] IDX_NEWPV [NUM_CNT] = '{IDX_C0_NEWPV, IDX_C1_NEWPV,
    IDX_C2_NEWPV};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL_RST_POL = 0;
  localparam int CTL_START_POL = 1;
  localparam int CTL_RATE = 2;
  localparam int CTL_DIR = 3;
  localparam int CTL_UPD_DIR = 4;
  localparam int CTL_UPD_PV = 5;
  localparam int CTL_UPD_CV = 6;
  localparam int CTL_EN = 7;
  localparam int ST_DIR = 5;
  localparam int ST_EQ = 6;
  localparam int ST_GT = 7;
  localparam int CFG_RST_EN = 2;
  localparam int CFG_START_EN = 3;
  localparam int CFG_STRIDE = 8;
  localparam int EV_EQ = 0;
  localparam int EV_DIR = 1;
  localparam int EV_RST = 2;
  localparam int EV_STRIDE = 3;
  localparam int EV_W = 9;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL0_MASK = 8'hfd;
  localparam logic [7:0] CTRL_MASK = 8'hff;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [EV_W-1:0] EV_RST_VAL = 9'h000;

  typedef enum logic [1:0] {
    MODE_INT_DIR,
    MODE_EXT_DIR,
    MODE_QUAD,
    MODE_QUAD_ALT
  } thsc_mode_t;

endpackage

// File: dv/thsc_pin_model.sv
// Purpose: quadrature pin source for the three counters
// Assumes: step requests are spaced by the bench, slower than a quarter of clk
// Notes: pulse pin is channel A, direction pin is channel B
`timescale 1ns/10ps

module thsc_pin_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] stepReq,
  input wire logic up,
  output logic [2:0] cntPulse,
  output logic [2:0] cntDir
);
  logic [1:0] phase_r [3];

  // gray sequence 00,10,11,01 when stepping up
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (reset) begin
        phase_r[i] <= 2'h0;
      end else if (stepReq[i]) begin
        phase_r[i] <= up ? phase_r[i] + 2'h1 : phase_r[i] - 2'h1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cntPulse[i] = phase_r[i][0] ^ phase_r[i][1];
      cntDir[i] = phase_r[i][1];
    end
  end
endmodule // thsc_pin_model

// File: dv/thsc_monitor.sv
// Purpose: bus and status checks at the counter block ports
// Assumes: one clock, synchronous active-high reset
// Notes: read index captured at the read address handshake
`timescale 1ns/10ps

module thsc_monitor
  import thsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [thsc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [thsc_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [IDX_W-1:0] rdIdx_r;
  logic isStat;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdIdx_r <= 7'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rdIdx_r <= s_axi_araddr[8:2];
    end
  end
  assign isStat = rdIdx_r == IDX_C0_STATUS || rdIdx_r == IDX_C1_STATUS ||
    rdIdx_r == IDX_C2_STATUS;

  sequence arTaken; s_axi_arvalid && s_axi_arready; endsequence
  sequence awTaken; s_axi_awvalid && s_axi_awready; endsequence
  sequence wTaken; s_axi_wvalid && s_axi_wready; endsequence

  stat_rsvd_a: assert property (s_axi_rvalid && isStat |-> s_axi_rresp == RESP_OKAY
    && s_axi_rdata[4:0] == 5'h0 && s_axi_rdata[31:8] == 24'h00_0000) else $error("status bits");
  eq_gt_excl_a: assert property (s_axi_rvalid && isStat |->
    !(s_axi_rdata[ST_EQ] && s_axi_rdata[ST_GT])) else $error("equal and greater");
  load_zero_a: assert property (s_axi_rvalid && rdIdx_r == IDX_LOAD |->
    s_axi_rdata == 32'h0000_0000) else $error("load strobe readback");
  ctrl0_rsvd_a: assert property (s_axi_rvalid && rdIdx_r == IDX_C0_CTRL |->
    !s_axi_rdata[CTL_START_POL]) else $error("ctrl0 reserved bit");
  rd_lat_a: assert property (arTaken |=> s_axi_rvalid) else $error("read latency");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data hold");
  wr_resp_a: assert property (awTaken and wTaken |-> ##[1:3] s_axi_bvalid)
    else $error("write response");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response hold");
  unmapped_a: assert property (s_axi_rvalid && (rdIdx_r < 7'h24 || rdIdx_r > 7'h49) |->
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
endmodule // thsc_monitor

bind thsc_top thsc_monitor u_monitor (.clk(clk), .reset(reset),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: dv/testbench.sv
// Purpose: self-checking bench for the triple fast counter block
// Assumes: pin changes reach the count three edges later
// Notes: registers reached through a small AXI4-Lite master
`timescale 1ns/10ps

module testbench;
  import thsc_pkg::*;
  logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, up;
  logic [8:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] cntPulse, cntDir, cntReset, cntStart, stepReq;
  int numErrors, compares;

  thsc_top DUT (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cntPulse(cntPulse), .cntDir(cntDir), .cntReset(cntReset), .cntStart(cntStart), .irq(irq));
  thsc_pin_model PINS (.clk(clk), .reset(reset), .stepReq(stepReq), .up(up),
    .cntPulse(cntPulse), .cntDir(cntDir));

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [6:0] idx, input logic [31:0] v);
    awaddr <= {idx, 2'b00};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      numErrors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rdc(input logic [6:0] idx, input logic [31:0] e, input string nm);
    rd(idx);
    chk(nm, e, d);
  endtask

  task automatic steps(input logic [2:0] m, input int n);
    repeat (n) begin
      stepReq <= m;
      @(posedge clk);
      stepReq <= 3'b000;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("irq", 32'h0000_0000, irq);
    rdc(IDX_C0_CTRL, 32'h0000_0000, "ctrl0");
    rdc(IDX_C1_STATUS, 32'h0000_0040, "status1");
  endtask

  task automatic t_load();
    wr(IDX_C1_NEWCV, 32'h0000_0005);
    wr(IDX_C1_NEWPV, 32'h0000_0005);
    wr(IDX_C1_CTRL, 32'h0000_0078);
    wr(IDX_LOAD, 32'h0000_0002);
    rdc(IDX_C1_STATUS, 32'h0000_0060, "status1");
    rdc(IDX_LOAD, 32'h0000_0000, "load");
    wr(IDX_C1_STATUS, 32'h0000_0000);
    rdc(IDX_C1_STATUS, 32'h0000_0060, "status1");
    wr(IDX_C1_NEWCV, 32'h0001_0005);
    wr(IDX_C1_CTRL, 32'h0000_0040);
    wr(IDX_LOAD, 32'h0000_0002);
    rdc(IDX_C1_STATUS, 32'h0000_00a0, "status1");
    rdc(IDX_COUNT0 + 7'h01, 32'h0001_0005, "count1");
  endtask

  task automatic t_pulse();
    wr(IDX_C0_CTRL, 32'h0000_0018);
    wr(IDX_LOAD, 32'h0000_0001);
    steps(3'b001, 8);
    rdc(IDX_COUNT0, 32'h0000_0000, "count0");
    wr(IDX_C0_CTRL, 32'h0000_009a);
    rdc(IDX_C0_CTRL, 32'h0000_0098, "ctrl0");
    steps(3'b001, 8);
    rdc(IDX_COUNT0, 32'h0000_0002, "count0");
    wr(IDX_C0_CTRL, 32'h0000_0090);
    wr(IDX_LOAD, 32'h0000_0001);
    steps(3'b001, 4);
    rdc(IDX_COUNT0, 32'h0000_0001, "count0");
    rdc(IDX_C0_STATUS, 32'h0000_0080, "status0");
    // pulse with direction from pin B: B low at the A rise, so one step down
    wr(IDX_CONFIG, 32'h0000_0001);
    steps(3'b001, 4);
    rdc(IDX_COUNT0, 32'h0000_0000, "count0");
    rdc(IDX_C0_STATUS, 32'h0000_0040, "status0");
  endtask

  task automatic t_quad();
    wr(IDX_CONFIG, 32'h0002_0002);
    for (int k = 0; k < 2; k++) begin
      wr(IDX_C0_CTRL, k ? 32'h0000_00c4 : 32'h0000_00c0);
      wr(IDX_C2_CTRL, k ? 32'h0000_00c4 : 32'h0000_00c0);
      wr(IDX_LOAD, 32'h0000_0005);
      steps(3'b101, 4);
      rdc(IDX_COUNT0, k ? 32'h0000_0001 : 32'h0000_0004, "count0");
      rdc(IDX_COUNT0 + 7'h02, k ? 32'h0000_0001 : 32'h0000_0004, "count2");
    end
    // one reverse cycle at 1x: count back to zero, direction shown as down
    up <= 1'b0;
    steps(3'b100, 4);
    up <= 1'b1;
    rdc(IDX_C2_STATUS, 32'h0000_0040, "status2");
  endtask

  task automatic t_pins();
    wr(IDX_CONFIG, 32'h0000_0404);
    wr(IDX_IRQ_MASK, 32'h0000_0020);
    wr(IDX_C1_CTRL, 32'h0000_0080);
    cntReset <= 3'b010;
    repeat (6) @(posedge clk);
    rdc(IDX_COUNT0 + 7'h01, 32'h0000_0000, "count1");
    rdc(IDX_COUNT0, 32'h0000_0001, "count0");
    chk("irq", 32'h0000_0001, irq);
    wr(IDX_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0000_0000, irq);
    wr(IDX_C0_CTRL, 32'h0000_0081);
    rdc(IDX_COUNT0, 32'h0000_0000, "count0");
    wr(IDX_C1_CTRL, 32'h0000_00c1);
    wr(IDX_LOAD, 32'h0000_0002);
    rdc(IDX_COUNT0 + 7'h01, 32'h0001_0005, "count1");
    cntReset <= 3'b000;
    repeat (6) @(posedge clk);
    rdc(IDX_COUNT0 + 7'h01, 32'h0000_0000, "count1");
    wr(IDX_IRQ_STAT, 32'h0000_01ff);
    wr(IDX_CONFIG, 32'h000a_0000);
    wr(IDX_C2_CTRL, 32'h0000_00c6);
    cntStart <= 3'b100;
    wr(IDX_LOAD, 32'h0000_0004);
    steps(3'b100, 4);
    rdc(IDX_COUNT0 + 7'h02, 32'h0000_0000, "count2");
    cntStart <= 3'b000;
    steps(3'b100, 4);
    rdc(IDX_COUNT0 + 7'h02, 32'h0000_0001, "count2");
  endtask

  task automatic t_unmapped();
    rd(7'h10);
    chk("rresp", RESP_SLVERR, r);
    wr(7'h10, 32'h0000_0001);
    chk("bresp", RESP_SLVERR, r);
  endtask

  task automatic summarize();
    if (numErrors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #2_000_000;
    numErrors++;
    summarize();
  end

  initial begin
    {reset, up} = 2'b11;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = '0;
    {cntReset, cntStart, stepReq} = '0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_load();
    t_pulse();
    t_quad();
    t_pins();
    t_unmapped();
    summarize();
  end
endmodule // testbench
